// ---- logic/tlb_pkg.sv ----
// Package of constants and types for the DMA address translator
// Functional notes
// - 64-entry table maps 4 MB onto 64 KB pages
// - Only DMA lookups translate; processor never does
// - Bypass needs host permit and channel enable
// - Host and DMA engine both write entries
// - Pointer bit 28 picks linear or tiled
// - Linear: index bits 21:16, offset bits 15:0
// - Tiled index is bits 21:19 then 11:9
// - Tiled offset is bits 18:12 then 8:0
// - Linear window 0x0080_0000 to 0x00bf_fffc
// - Tiled window 0x1080_0000 to 0x10bf_fffc
// - Unused pointer ranges raise DMA error
// - Invalid entry raises miss, no access
// - Entry: valid b0, write b1, page 31:16
// - Old revision copies second line chroma
// - New revision keeps even lines, drops odd
// - Tiles change page every 512 by 128
// - Writes need the entry's write flag
package tlb_pkg;
  localparam int unsigned ENTRIES = 64;
  localparam int unsigned IDX_W = 6;
  localparam logic [11:0] OFF_CFG = 12'h000;
  localparam logic [11:0] OFF_CTL1 = 12'h004;
  localparam logic [11:0] OFF_CTL2 = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_TLB = 12'h100;
  localparam int unsigned CFG_BYPASS_BIT = 0;
  localparam int unsigned CFG_REV_BIT = 1;
  localparam int unsigned CTL_BYPASS_BIT = 0;
  localparam int unsigned MODE_BIT = 28;
  localparam int unsigned ENT_VALID_BIT = 0;
  localparam int unsigned ENT_WRITE_BIT = 1;
  localparam logic [31:0] LIN_LO = 32'h0080_0000;
  localparam logic [31:0] LIN_HI = 32'h00bf_fffc;
  localparam logic [31:0] TIL_LO = 32'h1080_0000;
  localparam logic [31:0] TIL_HI = 32'h10bf_fffc;
  localparam logic [31:0] ERR_TOP = 32'h2000_0000;
  localparam logic [31:0] ERR_MID = 32'h1000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic chan;
    logic write;
    logic [31:0] ptr;
  } lookup_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] paddr;
    logic miss;
    logic dma_error;
    logic denied;
  } lookup_rsp_t;

  typedef struct packed {
    logic valid;
    logic split;
    logic rev_new;
    logic odd_line;
    logic [15:0] chroma;
  } chroma_in_t;
endpackage

// ---- logic/tlb_ram.sv ----
// Translation table storage with registered read port
`timescale 1ns/1ps
module tlb_ram
  import tlb_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [5:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem [ENTRIES];

  // Contents undefined after reset
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule

// ---- logic/dma_tlb_address_translator.sv ----
// DMA address translator: table, lookup, range checks, chroma pick
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module dma_tlb_address_translator
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_tlb_we,
  input wire logic [5:0] dma_tlb_idx,
  input wire logic [31:0] dma_tlb_data,
  input wire tlb_pkg::lookup_req_t req,
  output tlb_pkg::lookup_rsp_t rsp,
  input wire tlb_pkg::chroma_in_t chroma_in,
  output logic chroma_we,
  output logic [15:0] chroma_data
);
  import tlb_pkg::*;

  // ***************************************
  // Register bus decode
  // ***************************************
  logic [31:0] cfg_q;
  logic ctl1_q;
  logic ctl2_q;
  logic [3:0] stat_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic rd_pend_q;

  wire setup = psel && !penable;
  wire sel_cfg = paddr == OFF_CFG;
  wire sel_ctl1 = paddr == OFF_CTL1;
  wire sel_ctl2 = paddr == OFF_CTL2;
  wire sel_stat = paddr == OFF_STAT;
  wire sel_tlb = paddr[11:8] == OFF_TLB[11:8] && paddr[1:0] == 2'b00;
  wire [5:0] bus_idx = paddr[7:2];
  wire mapped = sel_cfg || sel_ctl1 || sel_ctl2 || sel_stat || sel_tlb;
  wire bus_wr = setup && pwrite && mapped;
  wire host_tlb_we = bus_wr && sel_tlb;

  // ***************************************
  // Table and its write arbitration
  // ***************************************
  wire tlb_we = host_tlb_we || dma_tlb_we;
  wire [5:0] tlb_waddr = host_tlb_we ? bus_idx : dma_tlb_idx;
  wire [31:0] tlb_wdata = host_tlb_we ? pwdata : dma_tlb_data;
  logic [31:0] tlb_rdata;
  logic [5:0] look_idx;
  wire bus_rd_tlb = setup && !pwrite && sel_tlb;
  wire [5:0] tlb_raddr = bus_rd_tlb ? bus_idx : look_idx;

  tlb_ram u_ram (
    .clk(clk),
    .we(tlb_we),
    .waddr(tlb_waddr),
    .wdata(tlb_wdata),
    .raddr(tlb_raddr),
    .rdata(tlb_rdata)
  );

  // ***************************************
  // Lookup stage one: decode the pointer
  // ***************************************
  // Only the DMA request port reaches here; no processor path exists
  wire [31:0] ptr = req.ptr;
  wire tiled = ptr[MODE_BIT];
  wire [5:0] lin_idx = ptr[21:16];
  wire [5:0] til_idx = {ptr[21:19], ptr[11:9]};
  assign look_idx = tiled ? til_idx : lin_idx;
  wire [15:0] lin_off = ptr[15:0];
  wire [15:0] til_off = {ptr[18:12], ptr[8:0]};
  wire in_lin = ptr >= LIN_LO && ptr <= LIN_HI;
  wire in_til = ptr >= TIL_LO && ptr <= TIL_HI;
  wire in_err = ptr >= ERR_TOP || ptr < LIN_LO
    || (ptr >= ERR_MID && ptr < TIL_LO);
  wire chan_byp = req.chan ? ctl2_q : ctl1_q;
  wire bypass = cfg_q[CFG_BYPASS_BIT] && chan_byp;
  // Reserved spaces count as unmapped too
  wire range_bad = !bypass && (in_err || !(in_lin || in_til));

  logic s1_valid_q;
  logic s1_bypass_q;
  logic s1_bad_q;
  logic s1_write_q;
  logic [15:0] s1_off_q;
  logic [31:0] s1_ptr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s1_valid_q <= 1'b0;
    else
      s1_valid_q <= req.valid && !bus_rd_tlb;
    s1_bypass_q <= bypass;
    s1_bad_q <= range_bad;
    s1_write_q <= req.write;
    s1_off_q <= tiled ? til_off : lin_off;
    s1_ptr_q <= ptr;
  end

  // ***************************************
  // Lookup stage two: entry check and answer
  // ***************************************
  wire ent_valid = tlb_rdata[ENT_VALID_BIT];
  wire ent_write = tlb_rdata[ENT_WRITE_BIT];
  wire [15:0] ent_page = tlb_rdata[31:16];
  wire miss_d = !s1_bypass_q && !s1_bad_q && !ent_valid;
  wire deny_d = !s1_bypass_q && !s1_bad_q && ent_valid
    && s1_write_q && !ent_write;
  wire [31:0] paddr_d = s1_bypass_q ? s1_ptr_q : {ent_page, s1_off_q};
  lookup_rsp_t rsp_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= s1_valid_q;
      rsp_q.dma_error <= s1_valid_q && s1_bad_q;
      rsp_q.miss <= s1_valid_q && miss_d;
      rsp_q.denied <= s1_valid_q && deny_d;
      rsp_q.paddr <= (s1_valid_q && !s1_bad_q && !miss_d) ? paddr_d : '0;
    end
  end
  assign rsp = rsp_q;

  // ***************************************
  // Chroma decimation for 4:2:2 to 4:2:0 split
  // ***************************************
  // Old: every line written, pair second overwrites first slot
  // New: even-numbered lines kept, odd-numbered dropped
  wire keep_new = !chroma_in.odd_line;
  wire chroma_keep = chroma_in.valid && (!chroma_in.split
    || !chroma_in.rev_new || keep_new);
  logic chroma_we_q;
  logic [15:0] chroma_data_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chroma_we_q <= 1'b0;
      chroma_data_q <= '0;
    end
    else
    begin
      chroma_we_q <= chroma_keep;
      chroma_data_q <= chroma_keep ? chroma_in.chroma : chroma_data_q;
    end
  end
  assign chroma_we = chroma_we_q;
  assign chroma_data = chroma_data_q;

  // ***************************************
  // Control registers and bus answer
  // ***************************************
  wire [3:0] stat_d = {rsp_q.denied, rsp_q.miss, rsp_q.dma_error,
    rsp_q.valid};
  wire [31:0] rd_mux = sel_cfg ? cfg_q
    : sel_ctl1 ? {31'h0, ctl1_q}
    : sel_ctl2 ? {31'h0, ctl2_q}
    : sel_stat ? {28'h0, stat_q} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q <= CFG_RESET;
      ctl1_q <= 1'b0;
      ctl2_q <= 1'b0;
      stat_q <= '0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      if (bus_wr && sel_cfg)
        cfg_q <= {30'h0, pwdata[CFG_REV_BIT], pwdata[CFG_BYPASS_BIT]};
      if (bus_wr && sel_ctl1)
        ctl1_q <= pwdata[CTL_BYPASS_BIT];
      if (bus_wr && sel_ctl2)
        ctl2_q <= pwdata[CTL_BYPASS_BIT];
      if (rsp_q.valid)
        stat_q <= stat_d;
      rd_pend_q <= bus_rd_tlb;
      // Table reads wait one cycle for the registered table port
      pready_q <= (setup && !bus_rd_tlb) || rd_pend_q;
      pslverr_q <= setup && !mapped;
      if (setup && !pwrite)
        prdata_q <= rd_mux;
      else if (rd_pend_q)
        prdata_q <= tlb_rdata;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ***************************************
  // Checks
  // ***************************************
  property p_err_range;
    @(posedge clk) disable iff (!rst_n)
    req.valid && !bus_rd_tlb && !bypass && ptr < LIN_LO
      |-> ##2 rsp.dma_error;
  endproperty
  a_err_range: assert property (p_err_range)
    else $error("low pointer gave no DMA error");

  property p_lin_off;
    @(posedge clk) disable iff (!rst_n)
    req.valid && !bus_rd_tlb && in_lin && !bypass
      |-> ##2 (rsp.miss || rsp.denied
        || rsp.paddr[15:0] == $past(ptr[15:0], 2));
  endproperty
  a_lin_off: assert property (p_lin_off)
    else $error("linear offset not carried");

  property p_til_off;
    @(posedge clk) disable iff (!rst_n)
    req.valid && !bus_rd_tlb && in_til && !bypass
      |-> ##2 (rsp.miss || rsp.denied || rsp.paddr[15:0]
        == {$past(ptr[18:12], 2), $past(ptr[8:0], 2)});
  endproperty
  a_til_off: assert property (p_til_off)
    else $error("tiled offset wrong");

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
    req.valid && !bus_rd_tlb && !cfg_q[CFG_BYPASS_BIT] && in_err
      |-> ##2 rsp.dma_error;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass without host permit");

  property p_one_fault;
    @(posedge clk) disable iff (!rst_n)
    rsp.valid |-> $onehot0({rsp.miss, rsp.dma_error, rsp.denied});
  endproperty
  a_one_fault: assert property (p_one_fault)
    else $error("several faults at once");

  property p_miss_no_addr;
    @(posedge clk) disable iff (!rst_n)
    rsp.miss |-> rsp.paddr == 32'h0;
  endproperty
  a_miss_no_addr: assert property (p_miss_no_addr)
    else $error("miss still produced an address");

  property p_new_drop;
    @(posedge clk) disable iff (!rst_n)
    chroma_in.valid && chroma_in.split && chroma_in.rev_new
      && chroma_in.odd_line |=> !chroma_we;
  endproperty
  a_new_drop: assert property (p_new_drop)
    else $error("second line chroma not dropped");

  property p_old_keep;
    @(posedge clk) disable iff (!rst_n)
    chroma_in.valid && !chroma_in.rev_new
      |=> chroma_we && chroma_data == $past(chroma_in.chroma);
  endproperty
  a_old_keep: assert property (p_old_keep)
    else $error("old mode line chroma lost");

  // ***************************************
  // Lookup pipeline, bus timing and chroma keep checks
  // ***************************************
  sequence s_look_taken;
    req.valid && !bus_rd_tlb;
  endsequence

  sequence s_answer;
    ##2 rsp.valid;
  endsequence

  property p_answer_two;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken |-> s_answer;
  endproperty
  a_answer_two: assert property (p_answer_two)
    else $error("lookup answer not two cycles later");

  property p_index;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken |-> tlb_raddr == (ptr[MODE_BIT] ? {ptr[21:19], ptr[11:9]}
      : ptr[21:16]);
  endproperty
  a_index: assert property (p_index)
    else $error("table index not taken from pointer");

  property p_err_ranges;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken ##0 (!bypass && (ptr >= ERR_TOP
      || (ptr >= ERR_MID && ptr < TIL_LO))) |-> ##2 rsp.dma_error;
  endproperty
  a_err_ranges: assert property (p_err_ranges)
    else $error("unused range gave no DMA error");

  property p_windows;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken ##0 ((ptr >= LIN_LO && ptr <= LIN_HI)
      || (ptr >= TIL_LO && ptr <= TIL_HI)) |-> ##2 !rsp.dma_error;
  endproperty
  a_windows: assert property (p_windows)
    else $error("accessible window gave DMA error");

  property p_bypass_addr;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken ##0 bypass |-> ##2 rsp.paddr == $past(ptr, 2);
  endproperty
  a_bypass_addr: assert property (p_bypass_addr)
    else $error("bypass did not pass the pointer");

  property p_read_no_deny;
    @(posedge clk) disable iff (!rst_n)
    s_look_taken ##0 !req.write |-> ##2 !rsp.denied;
  endproperty
  a_read_no_deny: assert property (p_read_no_deny)
    else $error("read denied by write flag");

  property p_tbl_rd_wait;
    @(posedge clk) disable iff (!rst_n)
    bus_rd_tlb |=> !pready ##1 pready && prdata == $past(tlb_rdata);
  endproperty
  a_tbl_rd_wait: assert property (p_tbl_rd_wait)
    else $error("table read data not with ready");

  property p_new_keep;
    @(posedge clk) disable iff (!rst_n)
    chroma_in.valid && chroma_in.split && chroma_in.rev_new
      && !chroma_in.odd_line
      |=> chroma_we && chroma_data == $past(chroma_in.chroma);
  endproperty
  a_new_keep: assert property (p_new_keep)
    else $error("kept line chroma not written");
endmodule

// ---- verification/sys_mem_model.sv ----
// Model of system memory that counts accepted DMA beats
`timescale 1ns/1ps
module sys_mem_model
  import tlb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire tlb_pkg::lookup_rsp_t rsp,
  output logic [7:0] beats_q
);
  // Only clean responses reach memory
  wire logic take = rsp.valid & ~rsp.miss & ~rsp.dma_error
    & ~rsp.denied;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      beats_q <= 8'h00;
    else if (take)
      beats_q <= beats_q + 8'h01;
  end
endmodule

// ---- verification/dma_tlb_address_translator_tb.sv ----
// Testbench for the DMA address translator
`timescale 1ns/1ps
module dma_tlb_address_translator_tb;
  import tlb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic dma_tlb_we = 1'b0;
  logic [5:0] dma_tlb_idx = 6'h00;
  logic [31:0] dma_tlb_data = 32'h0;
  lookup_req_t req = '0;
  lookup_rsp_t rsp;
  chroma_in_t chroma_in = '0;
  logic chroma_we;
  logic [15:0] chroma_data;
  logic [7:0] beats;
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] bad_ptr [3] = '{32'h0, 32'h1000_0000, 32'h2000_0000};

  dma_tlb_address_translator i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dma_tlb_we(dma_tlb_we), .dma_tlb_idx(dma_tlb_idx),
    .dma_tlb_data(dma_tlb_data), .req(req), .rsp(rsp),
    .chroma_in(chroma_in), .chroma_we(chroma_we),
    .chroma_data(chroma_data));
  sys_mem_model i_mem (.clk(clk), .rst_n(rst_n), .rsp(rsp), .beats_q(beats));

  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic look(input logic ch, input logic wr, input logic [31:0] p,
    input logic [31:0] ep, input logic [2:0] ef);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{valid: 1'b1, chan: ch, write: wr, ptr: p};
    @(posedge clk);
    req.valid <= 1'b0;
    while (rsp.valid !== 1'b1 && k < 6)
    begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, rsp.valid}, 32'h1);
    chk({29'h0, rsp.denied, rsp.miss, rsp.dma_error}, {29'h0, ef});
    if (ef[2] == 1'b0)
      chk(rsp.paddr, ep);
  endtask

  task automatic cr(input logic rev, input logic odd, input logic [15:0] d,
    input logic ewe, input logic [15:0] ed);
    @(posedge clk);
    chroma_in <= '{valid: 1'b1, split: 1'b1, rev_new: rev, odd_line: odd,
      chroma: d};
    @(posedge clk);
    chroma_in.valid <= 1'b0;
    @(posedge clk);
    chk({31'h0, chroma_we}, {31'h0, ewe});
    chk({16'h0, chroma_data}, {16'h0, ed});
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_CFG, 32'h0);
    chk(rd, CFG_RESET);
    apb(1'b1, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFF_TLB + 12'h014, 32'h1234_0003);
    apb(1'b1, OFF_TLB + 12'h018, 32'h5555_0002);
    @(posedge clk);
    dma_tlb_we <= 1'b1;
    dma_tlb_idx <= 6'h0b;
    dma_tlb_data <= 32'habcd_0001;
    @(posedge clk);
    dma_tlb_we <= 1'b0;
    apb(1'b0, OFF_TLB + 12'h014, 32'h0);
    chk(rd, 32'h1234_0003);
    apb(1'b0, OFF_TLB + 12'h02c, 32'h0);
    chk(rd, 32'habcd_0001);
    $display("test table writes done");
    look(1'b0, 1'b0, 32'h0085_abcc, 32'h1234_abcc, 3'b000);
    look(1'b0, 1'b1, 32'h0085_abcc, 32'h1234_abcc, 3'b000);
    look(1'b1, 1'b0, 32'h108f_f7fc, 32'habcd_fffc,
      3'b000);
    look(1'b1, 1'b1, 32'h108f_f7fc, 32'h0, 3'b100);
    look(1'b0, 1'b0, 32'h0086_0000, 32'h0, 3'b010);
    apb(1'b0, OFF_STAT, 32'h0);
    chk(rd, 32'h5);
    foreach (bad_ptr[i])
      look(1'b0, 1'b0, bad_ptr[i], 32'h0, 3'b001);
    $display("test lookups done");
    apb(1'b1, OFF_CFG, 32'h1);
    look(1'b1, 1'b0, 32'h2000_0000, 32'h0, 3'b001);
    apb(1'b1, OFF_CTL2, 32'h1);
    look(1'b1, 1'b0, 32'h2000_0000, 32'h2000_0000, 3'b000);
    look(1'b0, 1'b0, 32'h2000_0000, 32'h0, 3'b001);
    chk({24'h0, beats}, 32'h4);
    $display("test bypass done");
    cr(1'b1, 1'b0, 16'h1111, 1'b1, 16'h1111);
    cr(1'b1, 1'b1, 16'h2222, 1'b0, 16'h1111);
    cr(1'b0, 1'b1, 16'h3333, 1'b1, 16'h3333);
    $display("test chroma done");
    summarize();
  end
endmodule
